// ---- rtl/occ_defines.svh ----
// Purpose: Constants for the oscillator control and reference clock output block
// Assumes: APB word addressing, 8-bit registers in the low byte
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH

// Register byte offsets
`define OCC_ADDR_LOCK_STATUS   12'h000
`define OCC_ADDR_FRC_POST      12'h004
`define OCC_ADDR_PLL_USB       12'h008
`define OCC_ADDR_FRC_TRIM      12'h00C
`define OCC_ADDR_REF_BASE      12'h010
`define OCC_ADDR_REF_STRIDE    12'h010
`define OCC_ADDR_REF_CTRL      12'h000
`define OCC_ADDR_REF_SRC       12'h004
`define OCC_ADDR_REF_DIV_LO    12'h008
`define OCC_ADDR_REF_DIV_HI    12'h00C
`define OCC_ADDR_MOD_DISABLE   12'h030

// Lock and status register bits
`define OCC_BIT_CLK_LOCK       7
`define OCC_BIT_PIN_LOCK       6
`define OCC_BIT_PLL_LOCK       5
`define OCC_BIT_CLK_FAIL       3
`define OCC_BIT_PRI_KEEP       2
`define OCC_BIT_SEC_FORCE      1

// PLL and USB register fields
`define OCC_BIT_PLL_FORCE      5
`define OCC_USB_MSB            7
`define OCC_USB_LSB            6

// Reference control register bits
`define OCC_BIT_REF_ON         7
`define OCC_BIT_REF_PIN        4
`define OCC_BIT_REF_SLEEP      3
`define OCC_BIT_REF_ACTIVE     0

// Reset values
`define OCC_RST_FRC_POST       3'h1
`define OCC_RST_USB            2'h0
`define OCC_RST_TRIM           6'h00
`define OCC_RST_SRC            4'h0
`define OCC_RST_DIV            15'h0000

// Field widths
`define OCC_W_SRC              4
`define OCC_W_DIV              15
`define OCC_N_REF              2

`endif

// ---- rtl/occ_pkg.sv ----
// Purpose: Types shared by the oscillator control block
// Assumes: Nothing beyond the defines header
// Notes:   Source codes follow the reference source field
package occ_pkg;

  // Reference base clock source codes
  typedef enum logic [3:0] {
    OCC_SRC_SYSTEM    = 4'h0,
    OCC_SRC_PERIPH    = 4'h1,
    OCC_SRC_PRIMARY   = 4'h2,
    OCC_SRC_FAST_RC   = 4'h3,
    OCC_SRC_LOW_PWR   = 4'h4,
    OCC_SRC_SECONDARY = 4'h5,
    OCC_SRC_PLL       = 4'h6
  } occ_src_type;

endpackage

// ---- rtl/occ_refclk_gen.sv ----
// Purpose: One reference clock output generator
// Assumes: Base clock arrives as a level sampled on the core clock
// Notes:   Start and stop only while the output is low
`timescale 1ns/1ps
`default_nettype none
`include "occ_defines.svh"

module occ_refclk_gen
  import occ_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rstn,
  input  wire logic                   i_mod_disable,
  input  wire logic                   i_enable,
  input  wire logic                   i_pin_en,
  input  wire logic                   i_sleep_stop,
  input  wire logic                   i_base,
  input  wire logic [`OCC_W_DIV-1:0]  i_div,
  output logic                        o_pin,
  output logic                        o_oe,
  output logic                        o_active
);

  logic                  en_s1_r;
  logic                  en_s2_r;
  logic                  base_d_r;
  logic                  run_r;
  logic                  out_r;
  logic [`OCC_W_DIV-1:0] cnt_r;
  logic                  want_run;
  logic                  base_rise;
  logic                  div_hit;
  logic                  run_nxt;
  logic                  out_nxt;
  logic [`OCC_W_DIV-1:0] cnt_nxt;

  // Run decision and divider stepping
  assign want_run  = en_s2_r & ~i_sleep_stop;
  assign base_rise = i_base & ~base_d_r;
  assign div_hit   = (cnt_r == i_div - `OCC_W_DIV'(1));
  assign run_nxt   = out_r ? run_r : want_run;
  assign cnt_nxt   = (!run_r || (base_rise && div_hit)) ? '0
                   : base_rise ? cnt_r + `OCC_W_DIV'(1) : cnt_r;
  assign out_nxt   = !run_r ? 1'b0
                   : (i_div == `OCC_RST_DIV) ? i_base
                   : (base_rise && div_hit) ? ~out_r : out_r;

  // Enable synchroniser and generator state, held in reset when disabled
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_s1_r  <= 1'b0;
      en_s2_r  <= 1'b0;
      base_d_r <= 1'b0;
      run_r    <= 1'b0;
      out_r    <= 1'b0;
      cnt_r    <= '0;
      o_pin    <= 1'b0;
      o_oe     <= 1'b0;
      o_active <= 1'b0;
    end else if (i_mod_disable) begin
      en_s1_r  <= 1'b0;
      en_s2_r  <= 1'b0;
      base_d_r <= 1'b0;
      run_r    <= 1'b0;
      out_r    <= 1'b0;
      cnt_r    <= '0;
      o_pin    <= 1'b0;
      o_oe     <= 1'b0;
      o_active <= 1'b0;
    end else begin
      en_s1_r  <= i_enable;
      en_s2_r  <= en_s1_r;
      base_d_r <= i_base;
      run_r    <= run_nxt;
      out_r    <= out_nxt;
      cnt_r    <= cnt_nxt;
      o_pin    <= out_nxt & i_pin_en;
      o_oe     <= run_nxt & i_pin_en;
      o_active <= en_s2_r | run_nxt;
    end
  end

endmodule // occ_refclk_gen
`default_nettype wire

// ---- rtl/occ_osc_control.sv ----
// Purpose: Oscillator lock, status, postscaler and trim registers with
//          two reference clock output generators behind an APB slave
// Assumes: All clock and request inputs synchronous to i_core_clk
// Notes:   One wait-free access cycle; unmapped addresses answer pslverr
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "occ_defines.svh"

module occ_osc_control
  import occ_pkg::*;
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_por_rstn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Device status and requests
  input  wire logic                 i_pin_lock_one_way,
  input  wire logic                 i_clock_fail_event,
  input  wire logic                 i_pll_locked,
  input  wire logic                 i_pll_timer_done,
  input  wire logic                 i_pll_is_sys_src,
  input  wire logic                 i_secondary_req,
  input  wire logic                 i_osc_other_req,
  input  wire logic                 i_sleep,
  input  wire logic                 i_switch_req,
  // Candidate base clocks, sampled levels
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_periph_clk,
  input  wire logic                 i_primary_clk,
  input  wire logic                 i_fast_rc_clk,
  input  wire logic                 i_low_power_rc_clk,
  input  wire logic                 i_secondary_clk,
  input  wire logic                 i_pll_clk,
  // Oscillator controls
  output logic                      o_switch_grant,
  output logic                      o_pin_map_lock,
  output logic                      o_pll_run,
  output logic                      o_primary_osc_run,
  output logic                      o_secondary_osc_run,
  output logic                      o_fast_rc_run,
  output logic                      o_low_power_rc_run,
  output logic [2:0]                o_fast_rc_postscale_sel,
  output logic [1:0]                o_usb_clock_postscale_sel,
  output logic [5:0]                o_fast_rc_trim_value,
  // Reference clock pins
  output logic [`OCC_N_REF-1:0]     o_refclk_out,
  output logic [`OCC_N_REF-1:0]     o_refclk_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Register state

  // Lock, status and selection fields
  logic                         clock_select_lock_r;
  logic                         pin_map_lock_r;
  logic                         clock_fail_flag_r;
  logic                         primary_osc_sleep_keep_r;
  logic                         secondary_osc_force_on_r;
  logic [2:0]                   fast_rc_postscale_sel_r;
  logic [1:0]                   usb_clock_postscale_sel_r;
  logic                         pll_force_on_r;
  logic [5:0]                   fast_rc_trim_value_r;
  // Reference channel fields
  logic [`OCC_N_REF-1:0]        refclk_module_disable_r;
  logic [`OCC_N_REF-1:0]        ref_on_r;
  logic [`OCC_N_REF-1:0]        ref_pin_r;
  logic [`OCC_N_REF-1:0]        refclk_run_in_sleep_r;
  logic [`OCC_W_SRC-1:0]        refclk_source_sel_r [`OCC_N_REF];
  logic [`OCC_W_DIV-1:0]        refclk_divider_r    [`OCC_N_REF];
  // Per-channel views and oscillator requests
  logic [`OCC_N_REF-1:0]        ref_active;
  logic [`OCC_N_REF-1:0]        ref_base;
  logic [`OCC_N_REF-1:0]        ref_sleep_stop;
  logic [`OCC_N_REF-1:0]        ref_uses_pll;
  logic [`OCC_N_REF-1:0]        ref_keep_pri;
  logic [`OCC_N_REF-1:0]        ref_keep_sec;
  logic [`OCC_N_REF-1:0]        ref_keep_frc;
  logic [`OCC_N_REF-1:0]        ref_keep_low_power_rc;
  logic [`OCC_N_REF-1:0]        ref_hit_ctrl;
  logic [`OCC_N_REF-1:0]        ref_hit_src;
  logic [`OCC_N_REF-1:0]        ref_hit_lo;
  logic [`OCC_N_REF-1:0]        ref_hit_hi;
  logic [7:0]                   ref_rd [`OCC_N_REF];

  ////////////////////////////////////////////////////////////////////////
  // APB decode

  // Bus strobes, hits and PLL view
  logic       setup_ph;
  logic       wr_fire;
  logic       hit_lock;
  logic       hit_post;
  logic       hit_pll;
  logic       hit_trim;
  logic       hit_mdis;
  logic       hit_any;
  logic [7:0] wd;
  logic [7:0] rd_nxt;
  logic       pll_running;
  logic       pll_lock_status;

  // Strobes and address hits
  assign setup_ph = psel & ~penable;
  assign wr_fire  = psel & penable & pready & pwrite;
  assign wd       = pwdata[7:0];
  assign hit_lock = (paddr == `OCC_ADDR_LOCK_STATUS);
  assign hit_post = (paddr == `OCC_ADDR_FRC_POST);
  assign hit_pll  = (paddr == `OCC_ADDR_PLL_USB);
  assign hit_trim = (paddr == `OCC_ADDR_FRC_TRIM);
  assign hit_mdis = (paddr == `OCC_ADDR_MOD_DISABLE);
  assign hit_any  = hit_lock | hit_post | hit_pll | hit_trim | hit_mdis
                  | (|ref_hit_ctrl) | (|ref_hit_src) | (|ref_hit_lo) | (|ref_hit_hi);

  // PLL demand and lock view
  assign pll_running = pll_force_on_r
                     | ((i_pll_is_sys_src | (|ref_uses_pll)) & ~i_sleep);
  assign pll_lock_status = pll_running & (i_pll_locked | i_pll_timer_done);

  ////////////////////////////////////////////////////////////////////////
  // Per-channel decode, base select and generator

  genvar g;
  generate
    for (g = 0; g < `OCC_N_REF; g++) begin : g_ref
      localparam logic [11:0] BASE = `OCC_ADDR_REF_BASE + 12'(g) * `OCC_ADDR_REF_STRIDE;
      occ_src_type src;

      assign src              = occ_src_type'(refclk_source_sel_r[g]);
      assign ref_hit_ctrl[g]  = (paddr == BASE + `OCC_ADDR_REF_CTRL);
      assign ref_hit_src[g]   = (paddr == BASE + `OCC_ADDR_REF_SRC);
      assign ref_hit_lo[g]    = (paddr == BASE + `OCC_ADDR_REF_DIV_LO);
      assign ref_hit_hi[g]    = (paddr == BASE + `OCC_ADDR_REF_DIV_HI);
      // Base clock mux; reserved codes give a quiet base
      assign ref_base[g] = (src == OCC_SRC_SYSTEM)    ? i_sys_clk
                         : (src == OCC_SRC_PERIPH)    ? i_periph_clk
                         : (src == OCC_SRC_PRIMARY)   ? i_primary_clk
                         : (src == OCC_SRC_FAST_RC)   ? i_fast_rc_clk
                         : (src == OCC_SRC_LOW_PWR)   ? i_low_power_rc_clk
                         : (src == OCC_SRC_SECONDARY) ? i_secondary_clk
                         : (src == OCC_SRC_PLL)       ? i_pll_clk
                         : 1'b0;
      // System and peripheral clocks always stop in sleep
      assign ref_sleep_stop[g] = i_sleep & (~refclk_run_in_sleep_r[g]
                               | src == OCC_SRC_SYSTEM | src == OCC_SRC_PERIPH);
      assign ref_uses_pll[g]   = ref_on_r[g] & ~refclk_module_disable_r[g]
                               & (src == OCC_SRC_PLL)
                               & (~i_sleep | refclk_run_in_sleep_r[g]);
      assign ref_keep_pri[g]   = ref_on_r[g] & (src == OCC_SRC_PRIMARY) & refclk_run_in_sleep_r[g];
      assign ref_keep_sec[g]   = ref_on_r[g] & (src == OCC_SRC_SECONDARY)
                               & (~i_sleep | refclk_run_in_sleep_r[g]);
      assign ref_keep_frc[g]   = ref_on_r[g] & (src == OCC_SRC_FAST_RC) & refclk_run_in_sleep_r[g];
      assign ref_keep_low_power_rc[g]  = ref_on_r[g] & (src == OCC_SRC_LOW_PWR) & refclk_run_in_sleep_r[g];
      assign ref_rd[g] = ref_hit_ctrl[g] ? {ref_on_r[g], 2'h0, ref_pin_r[g],
                                            refclk_run_in_sleep_r[g], 2'h0, ref_active[g]}
                       : ref_hit_src[g]  ? {4'h0, refclk_source_sel_r[g]}
                       : ref_hit_lo[g]   ? refclk_divider_r[g][7:0]
                       : ref_hit_hi[g]   ? {1'b0, refclk_divider_r[g][14:8]}
                       : 8'h00;

      // Channel registers; module disable holds them at reset values
      always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          ref_on_r[g]              <= 1'b0;
          ref_pin_r[g]             <= 1'b0;
          refclk_run_in_sleep_r[g] <= 1'b0;
          refclk_source_sel_r[g]   <= `OCC_RST_SRC;
          refclk_divider_r[g]      <= `OCC_RST_DIV;
        end else if (refclk_module_disable_r[g]) begin
          ref_on_r[g]              <= 1'b0;
          ref_pin_r[g]             <= 1'b0;
          refclk_run_in_sleep_r[g] <= 1'b0;
          refclk_source_sel_r[g]   <= `OCC_RST_SRC;
          refclk_divider_r[g]      <= `OCC_RST_DIV;
        end else if (wr_fire) begin
          if (ref_hit_ctrl[g]) begin
            ref_on_r[g]              <= wd[`OCC_BIT_REF_ON];
            ref_pin_r[g]             <= wd[`OCC_BIT_REF_PIN];
            refclk_run_in_sleep_r[g] <= wd[`OCC_BIT_REF_SLEEP];
          end
          if (ref_hit_src[g]) begin
            refclk_source_sel_r[g] <= wd[`OCC_W_SRC-1:0];
          end
          if (ref_hit_lo[g]) begin
            refclk_divider_r[g][7:0] <= wd;
          end
          if (ref_hit_hi[g]) begin
            refclk_divider_r[g][14:8] <= wd[6:0];
          end
        end
      end

      // Generator for this output pin
      occ_refclk_gen u_gen (
        .i_core_clk    (i_core_clk),
        .i_rstn        (i_rstn),
        .i_mod_disable (refclk_module_disable_r[g]),
        .i_enable      (ref_on_r[g]),
        .i_pin_en      (ref_pin_r[g]),
        .i_sleep_stop  (ref_sleep_stop[g]),
        .i_base        (ref_base[g]),
        .i_div         (refclk_divider_r[g]),
        .o_pin         (o_refclk_out[g]),
        .o_oe          (o_refclk_oe[g]),
        .o_active      (ref_active[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read data mux

  // Only the addressed channel gives a non-zero view
  logic [7:0] ref_rd_or;
  assign ref_rd_or = ref_rd[0] | ref_rd[1];
  assign rd_nxt = hit_lock ? {clock_select_lock_r, pin_map_lock_r, pll_lock_status,
                              1'b0, clock_fail_flag_r, primary_osc_sleep_keep_r,
                              secondary_osc_force_on_r, 1'b0}
                : hit_post ? {5'h00, fast_rc_postscale_sel_r}
                : hit_pll  ? {usb_clock_postscale_sel_r, pll_force_on_r, 5'h00}
                : hit_trim ? {2'h0, fast_rc_trim_value_r}
                : hit_mdis ? {6'h00, refclk_module_disable_r}
                : ref_rd_or;

  // APB answer: ready in the first access cycle
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      prdata  <= (setup_ph && !pwrite) ? {24'h00_0000, rd_nxt} : 32'h0000_0000;
      pslverr <= setup_ph & ~hit_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lock and status register

  // Write strobe for this register
  logic lock_wr;
  assign lock_wr = wr_fire & hit_lock;

  // Lock, pin-map lock, fail flag and primary keep
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clock_select_lock_r      <= 1'b0;
      pin_map_lock_r           <= 1'b0;
      clock_fail_flag_r        <= 1'b0;
      primary_osc_sleep_keep_r <= 1'b0;
    end else begin
      if (lock_wr) begin
        clock_select_lock_r      <= wd[`OCC_BIT_CLK_LOCK];
        primary_osc_sleep_keep_r <= wd[`OCC_BIT_PRI_KEEP];
      end
      if (lock_wr && (wd[`OCC_BIT_PIN_LOCK] || !pin_map_lock_r || !i_pin_lock_one_way)) begin
        pin_map_lock_r <= wd[`OCC_BIT_PIN_LOCK];
      end
      if (i_clock_fail_event) begin
        clock_fail_flag_r <= 1'b1;
      end else if (lock_wr && !wd[`OCC_BIT_CLK_FAIL]) begin
        clock_fail_flag_r <= 1'b0;
      end
    end
  end

  // Secondary force survives all but power-on and brown-out reset
  always_ff @(posedge i_core_clk or negedge i_por_rstn) begin
    if (!i_por_rstn) begin
      secondary_osc_force_on_r <= 1'b0;
    end else if (lock_wr) begin
      secondary_osc_force_on_r <= wd[`OCC_BIT_SEC_FORCE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Postscaler, PLL, trim and module disable registers

  // Selection fields frozen while the clock-select lock is set
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fast_rc_postscale_sel_r   <= `OCC_RST_FRC_POST;
      usb_clock_postscale_sel_r <= `OCC_RST_USB;
      pll_force_on_r            <= 1'b0;
      fast_rc_trim_value_r      <= `OCC_RST_TRIM;
      refclk_module_disable_r   <= '0;
    end else begin
      if (wr_fire && hit_post && !clock_select_lock_r) begin
        fast_rc_postscale_sel_r <= wd[2:0];
      end
      if (wr_fire && hit_pll && !clock_select_lock_r) begin
        usb_clock_postscale_sel_r <= wd[`OCC_USB_MSB:`OCC_USB_LSB];
        pll_force_on_r            <= wd[`OCC_BIT_PLL_FORCE];
      end
      if (wr_fire && hit_trim) begin
        fast_rc_trim_value_r <= wd[5:0];
      end
      if (wr_fire && hit_mdis) begin
        refclk_module_disable_r <= wd[`OCC_N_REF-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator run controls

  // Registered requests to the oscillators and the switch grant
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_switch_grant            <= 1'b0;
      o_pin_map_lock            <= 1'b0;
      o_pll_run                 <= 1'b0;
      o_primary_osc_run         <= 1'b0;
      o_secondary_osc_run       <= 1'b0;
      o_fast_rc_run             <= 1'b0;
      o_low_power_rc_run        <= 1'b0;
      o_fast_rc_postscale_sel   <= `OCC_RST_FRC_POST;
      o_usb_clock_postscale_sel <= `OCC_RST_USB;
      o_fast_rc_trim_value      <= `OCC_RST_TRIM;
    end else begin
      o_switch_grant      <= i_switch_req & ~clock_select_lock_r;
      o_pin_map_lock      <= pin_map_lock_r;
      o_pll_run           <= pll_running;
      o_primary_osc_run   <= ~i_sleep | primary_osc_sleep_keep_r
                           | (|ref_keep_pri) | i_osc_other_req;
      o_secondary_osc_run <= secondary_osc_force_on_r | i_secondary_req
                           | (|ref_keep_sec);
      o_fast_rc_run       <= ~i_sleep | (|ref_keep_frc) | i_osc_other_req;
      o_low_power_rc_run  <= ~i_sleep | (|ref_keep_low_power_rc) | i_osc_other_req;
      o_fast_rc_postscale_sel   <= fast_rc_postscale_sel_r;
      o_usb_clock_postscale_sel <= usb_clock_postscale_sel_r;
      o_fast_rc_trim_value      <= fast_rc_trim_value_r;
    end
  end

endmodule // occ_osc_control
`default_nettype wire

// ---- dv/occ_osc_checker.sv ----
// Purpose: Port checks on occ_osc_control
// Assumes: Top ports only, bound below
// Notes:   Unmapped space starts above 0x030
`timescale 1ns/1ps
`default_nettype none
module occ_osc_checker (
  input wire logic        i_core_clk,
  input wire logic        i_rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        i_switch_req,
  input wire logic        o_switch_grant,
  input wire logic        i_pin_lock_one_way,
  input wire logic        o_pin_map_lock,
  input wire logic [2:0]  o_fast_rc_postscale_sel
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // Setup phase of a transfer
  sequence setup_s;
    psel && !penable;
  endsequence
  AST_READY: assert property (setup_s |=> pready && penable) else $error("no pready");
  AST_READY_ONE: assert property (pready |=> !pready) else $error("pready too long");
  AST_GRANT: assert property (!i_switch_req |=> !o_switch_grant) else $error("grant");
  AST_MAP_ERR: assert property (pready && paddr > 12'h030 |-> pslverr) else $error("no err");
  AST_MAP_OK: assert property (pready && paddr <= 12'h030 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("bad err");
  AST_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("hi");
  AST_PIN_LOCK: assert property (i_pin_lock_one_way && o_pin_map_lock |=> o_pin_map_lock)
    else $error("pin lock cleared");
  AST_PSC_RST: assert property ($rose(i_rstn) |-> o_fast_rc_postscale_sel == 3'h1)
    else $error("postscale reset");
endmodule // occ_osc_checker
bind occ_osc_control occ_osc_checker u_occ_osc_checker (.*);
`default_nettype wire

// ---- dv/occ_refclk_sink.sv ----
// Purpose: Receiver of a reference clock pin
// Assumes: Pin sampled on the core clock
// Notes:   Reports last period in core cycles
`timescale 1ns/1ps
`default_nettype none
module occ_refclk_sink (
  input  wire logic       i_core_clk,
  input  wire logic       i_pin,
  input  wire logic       i_oe,
  output logic [7:0]      o_period
);
  logic [7:0] cnt_r;
  logic       last_r;
  // Measure rising to rising edge only while driven
  always_ff @(posedge i_core_clk) begin
    last_r <= i_pin;
    cnt_r  <= (i_oe && i_pin && !last_r) ? 8'h1 : cnt_r + 8'h1;
    if (i_oe && i_pin && !last_r) o_period <= cnt_r;
  end
endmodule // occ_refclk_sink
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Register and reference clock tests
// Assumes: One wait-free APB access cycle
// Notes:   Primary and PLL base clocks toggle every core cycle
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_core_clk = 0, i_rstn = 0, i_por_rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_v;
  logic i_pin_lock_one_way = 0, i_clock_fail_event = 0, i_pll_locked = 0, i_sleep = 0;
  logic i_pll_timer_done = 0, i_pll_is_sys_src = 0, i_secondary_req = 0, i_switch_req = 0;
  logic i_osc_other_req = 0, i_sys_clk = 0, i_periph_clk = 0, i_primary_clk = 0;
  logic i_fast_rc_clk = 0, i_low_power_rc_clk = 0, i_secondary_clk = 0, i_pll_clk = 0;
  logic pready, pslverr, err_v, o_switch_grant, o_pin_map_lock, o_pll_run, o_primary_osc_run;
  logic o_secondary_osc_run, o_fast_rc_run, o_low_power_rc_run;
  logic [2:0] o_fast_rc_postscale_sel;
  logic [1:0] o_usb_clock_postscale_sel, o_refclk_out, o_refclk_oe;
  logic [5:0] o_fast_rc_trim_value;
  logic [7:0] per;
  int err_total = 0, check_count = 0, i;
  occ_osc_control u_occ_osc_control (.*);
  occ_refclk_sink u_occ_refclk_sink (.i_core_clk(i_core_clk), .i_pin(o_refclk_out[0]),
    .i_oe(o_refclk_oe[0]), .o_period(per));
  initial forever #25 i_core_clk = ~i_core_clk;
  // Primary and PLL base clocks at half the core rate
  always @(posedge i_core_clk) {i_primary_clk, i_pll_clk} <= ~{i_primary_clk, i_pll_clk};
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge i_core_clk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask
  task automatic end_sim;
    $display("Checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    i_por_rstn <= 1'b1;
    @(posedge i_core_clk);
    rdc(12'h004, 32'h1);
    rdc(12'h000, 32'h0);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, 12'h004, 32'(i));
      rdc(12'h004, 32'(i));
      apb(1'b1, 12'h008, 32'(i << 6));
      rdc(12'h008, 32'((i & 3) << 6));
      chk(32'(o_fast_rc_postscale_sel), 32'(i));
      chk(32'(o_usb_clock_postscale_sel), 32'(i & 3));
    end
    apb(1'b1, 12'h00C, 32'hFF);
    rdc(12'h00C, 32'h3F);
    chk(32'(o_fast_rc_trim_value), 32'h3F);
    $display("Register test done");
    apb(1'b1, 12'h000, 32'hFF);
    rdc(12'h000, 32'hC6);
    chk(32'(o_secondary_osc_run), 32'h1);
    chk(32'(o_pin_map_lock), 32'h1);
    apb(1'b1, 12'h004, 32'h5);
    rdc(12'h004, 32'h7);
    i_switch_req <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    chk(32'(o_switch_grant), 32'h0);
    i_pin_lock_one_way <= 1'b1;
    apb(1'b1, 12'h000, 32'h00);
    i_clock_fail_event <= 1'b1;
    @(posedge i_core_clk);
    i_clock_fail_event <= 1'b0;
    rdc(12'h000, 32'h48);
    chk(32'(o_secondary_osc_run), 32'h0);
    chk(32'(o_switch_grant), 32'h1);
    apb(1'b1, 12'h000, 32'h42);
    rdc(12'h000, 32'h42);
    i_rstn <= 1'b0;
    @(posedge i_core_clk);
    i_rstn <= 1'b1;
    @(posedge i_core_clk);
    rdc(12'h000, 32'h02);
    chk(32'(o_secondary_osc_run), 32'h1);
    i_sleep <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    chk(32'(o_primary_osc_run), 32'h0);
    apb(1'b1, 12'h000, 32'h06);
    apb(1'b1, 12'h008, 32'h20);
    i_pll_locked <= 1'b1;
    rdc(12'h000, 32'h26);
    chk(32'(o_primary_osc_run), 32'h1);
    chk(32'(o_pll_run), 32'h1);
    i_sleep <= 1'b0;
    apb(1'b1, 12'h008, 32'h00);
    rdc(12'h000, 32'h06);
    i_pll_is_sys_src <= 1'b1;
    rdc(12'h000, 32'h26);
    i_pll_is_sys_src <= 1'b0;
    $display("Lock test done");
    apb(1'b1, 12'h014, 32'h2);
    apb(1'b1, 12'h018, 32'h2);
    apb(1'b1, 12'h010, 32'h90);
    repeat (60) @(posedge i_core_clk);
    chk(32'(per), 32'h8);
    rdc(12'h010, 32'h91);
    i_sleep <= 1'b1;
    repeat (20) @(posedge i_core_clk);
    chk(32'(o_refclk_oe), 32'h0);
    i_sleep <= 1'b0;
    repeat (20) @(posedge i_core_clk);
    chk(32'(o_refclk_oe), 32'h1);
    apb(1'b1, 12'h010, 32'h10);
    repeat (20) @(posedge i_core_clk);
    chk(32'(o_refclk_oe), 32'h0);
    apb(1'b1, 12'h030, 32'h1);
    rdc(12'h010, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk(32'(err_v), 32'h1);
    $display("Reference clock test done");
    end_sim();
  end
  // Watchdog well past the expected run
  initial begin
    #2000000;
    err_total++;
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
